// [charge_consts.svh]
// Purpose: constants for the charge count accumulator register slice
// Assumes: byte-wide register access through the management bus engine
// Notes:   definitions only
//
// What this block does
// - Keep a 32-bit running total of charge current into the battery.
// - After each conversion with sign bit 0 and accumulation enabled, add result.
// - Total wraps past its maximum; host must read and clear it in time.
// - Writing the charge clear bit in the clear register zeroes the total, or loads the result of a same-cycle charge conversion.
// - Decode 10-bit location plus 2-bit bank; total sits in register bank.
`ifndef CHARGE_CONSTS_SVH
`define CHARGE_CONSTS_SVH

// ----------------------------------------------------------------
// map
// ----------------------------------------------------------------
`define REG_BANK          2'h1
`define ACCUM_BYTE0_ADDR  10'h024
`define ACCUM_BYTE1_ADDR  10'h025
`define ACCUM_BYTE2_ADDR  10'h026
`define ACCUM_BYTE3_ADDR  10'h027
`define ACC_CLEAR_ADDR    10'h062
`define CHARGE_CLEAR_BIT  2

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define RESULT_SIGN_BIT   15
`define ACCUM_RESET_VAL   32'h0000_0000
`define BYTE_ZERO         8'h00
`define RESULT_PAD        16'h0000

`endif

// [charge_pkg.sv]
// Purpose: types shared by the charge count accumulator files
// Assumes: nothing
// Notes:   numeric constants live in charge_consts.svh
package charge_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [9:0]  loc_addr_t;
  typedef logic [15:0] conv_result_t;
  typedef logic [31:0] accum_t;

  typedef enum logic [1:0] {
    BANK_EEPROM,
    BANK_REGS,
    BANK_TEST,
    BANK_RESERVED
  } bank_t;

endpackage : charge_pkg

// [charge_accum_core.sv]
// Purpose: 32-bit wrapping accumulator of charge-direction conversions
// Assumes: conversion strobe and result come from logic on the same clock
// Notes:   clear and add in one cycle loads the new result alone
`timescale 1ns/1ps
`default_nettype none
`include "charge_consts.svh"

module charge_accum_core
  import charge_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  // conversion side
  input  wire logic          conv_done,
  input  wire conv_result_t  conv_result,
  input  wire logic          accum_en,
  // control
  input  wire logic          clear,
  // state
  output var  accum_t        total_r
);

  logic   charge_dir;
  logic   do_add;
  accum_t addend;
  accum_t total_nxt;

  // ----------------------------------------------------------------
  // add decision
  // ----------------------------------------------------------------
  assign charge_dir = ~conv_result[`RESULT_SIGN_BIT];
  assign do_add     = conv_done & accum_en & charge_dir;
  assign addend     = {`RESULT_PAD, conv_result};

  // a clear must not swallow a conversion landing in the same cycle
  always_comb begin
    if (clear && do_add) begin
      total_nxt = addend;
    end else if (clear) begin
      total_nxt = `ACCUM_RESET_VAL;
    end else if (do_add) begin
      total_nxt = total_r + addend;
    end else begin
      total_nxt = total_r;
    end
  end

  // ----------------------------------------------------------------
  // running total
  // ----------------------------------------------------------------
  // plain modular add: no saturation, carry out is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      total_r <= `ACCUM_RESET_VAL;
    end else if (ce) begin
      total_r <= total_nxt;
    end
  end

endmodule : charge_accum_core
`default_nettype wire

// [charge_count_accumulator.sv]
// Purpose: charge count accumulator with its byte-wide register access
// Assumes: bus engine supplies one-cycle read and write strobes on CLK
// Notes:   byte 0 read freezes bytes 1..3 for a coherent multi-byte read
`timescale 1ns/1ps
`default_nettype none
`include "charge_consts.svh"

module charge_count_accumulator (
  // clock, reset, enable
  input  wire logic                   CLK,
  input  wire logic                   RSTN,
  input  wire logic                   CE,
  // register access from the management bus engine
  input  wire charge_pkg::bank_t      BANK_SEL,
  input  wire charge_pkg::loc_addr_t  LOC_ADDR,
  input  wire logic                   WR_STB,
  input  wire charge_pkg::byte_t      WR_DATA,
  input  wire logic                   RD_STB,
  output var  charge_pkg::byte_t      RD_DATA,
  output var  logic                   RD_VALID,
  output var  logic                   ADDR_HIT,
  // conversion results
  input  wire logic                   CONV_DONE,
  input  wire charge_pkg::conv_result_t CONV_RESULT,
  input  wire logic                   ACCUM_EN,
  // state view
  output var  charge_pkg::accum_t     CHARGE_ACCUMULATOR
);
  import charge_pkg::*;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic   in_reg_bank;
  logic   hit_b0;
  logic   hit_b1;
  logic   hit_b2;
  logic   hit_b3;
  logic   hit_clr;
  logic   hit_any;
  logic   charge_clear;
  accum_t total;

  assign in_reg_bank = (BANK_SEL == BANK_REGS);

  always_comb begin
    hit_b0  = 1'b0;
    hit_b1  = 1'b0;
    hit_b2  = 1'b0;
    hit_b3  = 1'b0;
    hit_clr = 1'b0;
    if (!in_reg_bank) begin
      hit_b0 = 1'b0;
    end else if (LOC_ADDR == `ACCUM_BYTE0_ADDR) begin
      hit_b0 = 1'b1;
    end else if (LOC_ADDR == `ACCUM_BYTE1_ADDR) begin
      hit_b1 = 1'b1;
    end else if (LOC_ADDR == `ACCUM_BYTE2_ADDR) begin
      hit_b2 = 1'b1;
    end else if (LOC_ADDR == `ACCUM_BYTE3_ADDR) begin
      hit_b3 = 1'b1;
    end else if (LOC_ADDR == `ACC_CLEAR_ADDR) begin
      hit_clr = 1'b1;
    end
  end

  assign hit_any = hit_b0 | hit_b1 | hit_b2 | hit_b3 | hit_clr;

  // clear acts on the write itself; the bit is not stored and reads 0
  assign charge_clear = CE & WR_STB & hit_clr & WR_DATA[`CHARGE_CLEAR_BIT];

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  charge_accum_core u_core (
    .clk         (CLK),
    .rst_n       (RSTN),
    .ce          (CE),
    .conv_done   (CONV_DONE),
    .conv_result (CONV_RESULT),
    .accum_en    (ACCUM_EN),
    .clear       (charge_clear),
    .total_r     (total)
  );

  // ----------------------------------------------------------------
  // coherent read snapshot
  // ----------------------------------------------------------------
  // without it an add between byte reads could tear the 32-bit value
  accum_t snap_r;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      snap_r <= `ACCUM_RESET_VAL;
    end else if (CE && RD_STB && hit_b0) begin
      snap_r <= total;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  byte_t rd_nxt;

  always_comb begin
    rd_nxt = `BYTE_ZERO;
    if (hit_b0) begin
      rd_nxt = total[7:0];
    end else if (hit_b1) begin
      rd_nxt = snap_r[15:8];
    end else if (hit_b2) begin
      rd_nxt = snap_r[23:16];
    end else if (hit_b3) begin
      rd_nxt = snap_r[31:24];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RD_DATA <= `BYTE_ZERO;
    end else if (CE && RD_STB) begin
      RD_DATA <= rd_nxt;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RD_VALID <= 1'b0;
    end else if (CE) begin
      RD_VALID <= RD_STB;
    end
  end

  // hit is reported with the answer so the engine can ack or nack
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ADDR_HIT <= 1'b0;
    end else if (CE) begin
      ADDR_HIT <= (RD_STB | WR_STB) & hit_any;
    end
  end

  // ----------------------------------------------------------------
  // state view
  // ----------------------------------------------------------------
  // one cycle behind the core total, taken from a flop of its own
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CHARGE_ACCUMULATOR <= `ACCUM_RESET_VAL;
    end else if (CE) begin
      CHARGE_ACCUMULATOR <= total;
    end
  end

endmodule : charge_count_accumulator
`default_nettype wire

// [charge_props.sv]
// Purpose: port checks for the charge accumulator
// Assumes: total view lags the internal total by one edge
// Notes:   bind at foot
`timescale 1ns/1ps
`default_nettype none
`include "charge_consts.svh"
module charge_props
  import charge_pkg::*;
(
  input wire logic         CLK, RSTN, CE, WR_STB, RD_STB, RD_VALID, ADDR_HIT,
  input wire bank_t        BANK_SEL,
  input wire loc_addr_t    LOC_ADDR,
  input wire byte_t        WR_DATA, RD_DATA,
  input wire logic         CONV_DONE, ACCUM_EN,
  input wire conv_result_t CONV_RESULT,
  input wire accum_t       CHARGE_ACCUMULATOR
);
  logic add_c, clr_c, map_c;
  assign add_c = CE && CONV_DONE && ACCUM_EN && !CONV_RESULT[`RESULT_SIGN_BIT];
  assign clr_c = CE && WR_STB && BANK_SEL == BANK_REGS && LOC_ADDR == `ACC_CLEAR_ADDR
                 && WR_DATA[`CHARGE_CLEAR_BIT];
  assign map_c = BANK_SEL == BANK_REGS
                 && LOC_ADDR inside {[`ACCUM_BYTE0_ADDR:`ACCUM_BYTE3_ADDR]};
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  AST_ADD: assert property (
    add_c && !clr_c ##1 CE |=> CHARGE_ACCUMULATOR ==
      $past(CHARGE_ACCUMULATOR) + {16'h0000, $past(CONV_RESULT, 2)})
    else $error("total did not grow by the result");
  AST_HOLD: assert property (
    CE && !add_c && !clr_c ##1 CE |=> $stable(CHARGE_ACCUMULATOR))
    else $error("total moved without cause");
  AST_CLEAR: assert property (
    clr_c && !add_c ##1 CE |=> CHARGE_ACCUMULATOR == `ACCUM_RESET_VAL)
    else $error("total not cleared");
  AST_BOTH: assert property (
    clr_c && add_c ##1 CE |=> CHARGE_ACCUMULATOR == {16'h0000, $past(CONV_RESULT, 2)})
    else $error("clear lost the same-cycle result");
  AST_LOW: assert property (
    CE && RD_STB && map_c && LOC_ADDR == `ACCUM_BYTE0_ADDR
      |=> RD_DATA == CHARGE_ACCUMULATOR[7:0])
    else $error("low byte read wrong");
  AST_HIT: assert property (
    CE && (RD_STB || WR_STB) && LOC_ADDR != `ACC_CLEAR_ADDR |=> ADDR_HIT == $past(map_c))
    else $error("address decode wrong");
  AST_IDLE: assert property (
    CE && !RD_STB && !WR_STB |=> !ADDR_HIT && !RD_VALID)
    else $error("answer without request");
  AST_RDV: assert property (
    CE && RD_STB |=> RD_VALID) else $error("read not answered");
  AST_UNMAP: assert property (
    CE && RD_STB && !map_c |=> RD_DATA == `BYTE_ZERO)
    else $error("unmapped read not zero");
endmodule : charge_props
bind charge_count_accumulator charge_props i_props (.CLK(CLK), .RSTN(RSTN), .CE(CE),
  .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_VALID(RD_VALID), .ADDR_HIT(ADDR_HIT),
  .BANK_SEL(BANK_SEL), .LOC_ADDR(LOC_ADDR), .WR_DATA(WR_DATA), .RD_DATA(RD_DATA),
  .CONV_DONE(CONV_DONE), .ACCUM_EN(ACCUM_EN), .CONV_RESULT(CONV_RESULT),
  .CHARGE_ACCUMULATOR(CHARGE_ACCUMULATOR));
`default_nettype wire

// [charge_host.sv]
// Purpose: host side of the register access
// Assumes: one-cycle strobes, answer one edge later
// Notes:   idle address and data show inverted last value
`timescale 1ns/1ps
`default_nettype none
module charge_host
  import charge_pkg::*;
(
  input wire logic       CLK,
  output var bank_t      BANK_SEL,
  output var loc_addr_t  LOC_ADDR,
  output var logic       WR_STB, RD_STB,
  output var byte_t      WR_DATA,
  input wire byte_t      RD_DATA,
  input wire logic       ADDR_HIT
);
  initial begin
    BANK_SEL = BANK_REGS;
    LOC_ADDR = 10'h3ff;
    WR_STB = 1'b0;
    RD_STB = 1'b0;
    WR_DATA = 8'hff;
  end
  // one transfer: strobe for one cycle, then sample read data and hit one edge later
  task automatic xfer(input bank_t b, input loc_addr_t a, input logic w, input byte_t d,
                      output byte_t q, output logic h);
    @(posedge CLK);
    BANK_SEL <= b;
    LOC_ADDR <= a;
    WR_DATA <= d;
    WR_STB <= w;
    RD_STB <= !w;
    @(posedge CLK);
    WR_STB <= 1'b0;
    RD_STB <= 1'b0;
    LOC_ADDR <= ~a;
    WR_DATA <= ~d;
    @(posedge CLK);
    q = RD_DATA;
    h = ADDR_HIT;
  endtask : xfer
endmodule : charge_host
`default_nettype wire

// [testbench.sv]
// Purpose: sequences of register and conversion calls
// Assumes: 25 MHz clock
// Notes:   wrap is left to the checker
`timescale 1ns/1ps
`default_nettype none
`include "charge_consts.svh"
module testbench;
  import charge_pkg::*;
  logic         CLK, RSTN, CE, CONV_DONE, ACCUM_EN, WR_STB, RD_STB, RD_VALID, ADDR_HIT, h;
  conv_result_t CONV_RESULT;
  bank_t        BANK_SEL;
  loc_addr_t    LOC_ADDR;
  byte_t        WR_DATA, RD_DATA, q;
  accum_t       CHARGE_ACCUMULATOR;
  int           bad_count, cmp_count;
  charge_count_accumulator i_dut (.CLK(CLK), .RSTN(RSTN), .CE(CE), .BANK_SEL(BANK_SEL),
    .LOC_ADDR(LOC_ADDR), .WR_STB(WR_STB), .WR_DATA(WR_DATA), .RD_STB(RD_STB),
    .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .ADDR_HIT(ADDR_HIT), .CONV_DONE(CONV_DONE),
    .CONV_RESULT(CONV_RESULT), .ACCUM_EN(ACCUM_EN), .CHARGE_ACCUMULATOR(CHARGE_ACCUMULATOR));
  charge_host i_host (.CLK(CLK), .BANK_SEL(BANK_SEL), .LOC_ADDR(LOC_ADDR), .WR_STB(WR_STB),
    .RD_STB(RD_STB), .WR_DATA(WR_DATA), .RD_DATA(RD_DATA), .ADDR_HIT(ADDR_HIT));
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  // byte 0 first so the upper bytes come from one snapshot
  task automatic rd32(input bank_t b, input logic [31:0] e, input logic eh);
    logic [31:0] w;
    for (int i = 0; i < 4; i++) begin
      i_host.xfer(b, `ACCUM_BYTE0_ADDR + 10'(i), 1'b0, 8'h00, q, h);
      w[8*i +: 8] = q;
      chk("hit", {31'h0, eh}, {31'h0, h});
    end
    chk("total", e, w);
  endtask : rd32
  task automatic conv(input conv_result_t r, input logic en);
    @(posedge CLK);
    CONV_DONE <= 1'b1;
    CONV_RESULT <= r;
    ACCUM_EN <= en;
    @(posedge CLK);
    CONV_DONE <= 1'b0;
    CONV_RESULT <= ~r;
  endtask : conv
  initial begin
    RSTN = 1'b0;
    CE = 1'b1;
    CONV_DONE = 1'b0;
    ACCUM_EN = 1'b0;
    CONV_RESULT = 16'h0000;
    repeat (12) @(posedge CLK);
    RSTN <= 1'b1;
    rd32(BANK_REGS, 32'h0, 1'b1);
    conv(16'h0005, 1'b1);
    conv(16'h1234, 1'b1);
    conv(16'h8010, 1'b1);
    conv(16'h0777, 1'b0);
    CE <= 1'b0;
    conv(16'h0010, 1'b1);
    CE <= 1'b1;
    rd32(BANK_REGS, 32'h1239, 1'b1);
    chk("view", 32'h1239, CHARGE_ACCUMULATOR);
    rd32(BANK_EEPROM, 32'h0, 1'b0);
    i_host.xfer(BANK_REGS, `ACCUM_BYTE1_ADDR, 1'b1, 8'hff, q, h);
    i_host.xfer(BANK_REGS, `ACC_CLEAR_ADDR, 1'b1, 8'hfb, q, h);
    rd32(BANK_REGS, 32'h1239, 1'b1);
    i_host.xfer(BANK_REGS, 10'h028, 1'b0, 8'h00, q, h);
    chk("unmapped", 32'h0, {23'h0, h, q});
    i_host.xfer(BANK_REGS, `ACC_CLEAR_ADDR, 1'b1, 8'h04, q, h);
    rd32(BANK_REGS, 32'h0, 1'b1);
    // clear and a charge conversion on one edge: the conversion survives
    fork
      i_host.xfer(BANK_REGS, `ACC_CLEAR_ADDR, 1'b1, 8'h04, q, h);
      conv(16'h0003, 1'b1);
    join
    chk("clear hit", 32'h1, {31'h0, h});
    rd32(BANK_REGS, 32'h3, 1'b1);
    conv(16'h7fff, 1'b1);
    rd32(BANK_REGS, 32'h8002, 1'b1);
    RSTN <= 1'b0;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    rd32(BANK_REGS, 32'h0, 1'b1);
    chk("view", 32'h0, CHARGE_ACCUMULATOR);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
